// >>> sdc_check.sv
/*
 Segment descriptor and selector checker with vector table validation.
 Assumes the execution unit presents one request per cycle with the
 descriptor already fetched; the answer stands one cycle later.
*/
// Our own choices: the register offsets and the plain strobed port.
// Contract
// - Vector table has 256 entries; only task, interrupt, trap gates accepted.
// - Vector table is used for software, external and exception vectors.
// - Eight-byte descriptors: base, 20-bit limit, granularity, level, type.
// - Access byte bit 7 clear means any access raises fault 11; the code raises fault 13 instead when another check also fails.
// - Segment privilege level comes from access byte bits 6 to 5.
// - Access byte bit 4 set means code or data, clear means system.
// - Expand-up data segments allow offsets up to and including the limit.
// - Expand-down data segments allow only offsets above the limit.
// - Data segment bit 1 clear refuses writes.
// - Conforming code executes only when current level is at least segment's.
// - Code segment bit 1 clear refuses data reads.
// - Accessed bit set on segment register load or selector test.
// - Granularity bit picks byte or 4-Kbyte limit units.
// - Base bits 31 to 24 have no effect and never reach address pins.
// - Physical address is the linear address cut to the physical width.
// - System types 2, 5, 9, B, C, E, F are recognised.
// - Table indicator picks global or per-task table; index picks entry.
// - Requester level is selector bits 1:0, index is upper 13 bits.
// - Effective level is the larger of requester and segment levels.
// - First global table slot is the null selector, never valid.
`timescale 1ns/1ps
module sdc_check (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Check request and answer
   input wire sdc_pkg::sdc_req_t req,
   output sdc_pkg::sdc_rsp_t rsp,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   function automatic logic [1:0] sdc_max2(
      input logic [1:0] a,
      input logic [1:0] b
   );
      return (a > b) ? a : b;
   endfunction

   logic [7:0] acc;
   logic [3:0] typ;
   logic [19:0] lim20;
   logic [31:0] eff_lim;
   logic [31:0] lin;
   logic [1:0] requester_privilege_level;
   logic [1:0] segment_privilege_level;
   logic [1:0] effective_privilege_level;
   logic lvl_low;
   logic is_vec;
   logic is_code;
   logic is_data;
   logic null_sel;
   logic not_pres;
   logic lim_bad;
   logic perm_bad;
   logic priv_bad;
   logic gp;
   logic [15:0] vlim;
   logic [15:0] fcnt;
   logic [7:0] last_vec;
   sdc_pkg::sdc_rsp_t next_rsp;
   logic [15:0] next_vlim;
   logic [15:0] next_fcnt;
   logic [7:0] next_last_vec;
   logic [31:0] next_rdata;

   always_comb begin
      acc = req.desc[sdc_pkg::SDC_ACC_LSB +: 8];
      typ = acc[3:0];
      lim20 = {req.desc[sdc_pkg::SDC_LIMH_LSB +: 4],
               req.desc[sdc_pkg::SDC_LIML_LSB +: 16]};
      eff_lim = req.desc[sdc_pkg::SDC_G_BIT] ?
                {lim20, sdc_pkg::SDC_GRAN_FILL} : {12'h000, lim20};
      // Upper base byte is dropped here so it cannot carry into the pins
      lin = {8'h00, req.desc[sdc_pkg::SDC_BASE_LSB +: 24]}
            + req.offset;
      requester_privilege_level = req.sel[1:0];
      segment_privilege_level = acc[sdc_pkg::SDC_A_PRIV +: 2];
      effective_privilege_level = sdc_max2(requester_privilege_level,
                                           segment_privilege_level);
      // Shared by read, write and load so the three level tests agree
      lvl_low = effective_privilege_level < req.current_privilege_level;
      is_vec = req.kind inside {sdc_pkg::SDC_VSW, sdc_pkg::SDC_VEXT,
                                sdc_pkg::SDC_VEXC};
      is_code = acc[sdc_pkg::SDC_A_S] & acc[sdc_pkg::SDC_A_E];
      is_data = acc[sdc_pkg::SDC_A_S] & ~acc[sdc_pkg::SDC_A_E];
      null_sel = ~req.sel[2] && (req.sel[15:3] == 13'h0000);
      not_pres = ~acc[sdc_pkg::SDC_A_P];
      if (is_data && acc[sdc_pkg::SDC_A_EDC]) begin
         lim_bad = req.offset <= eff_lim;
      end else begin
         lim_bad = req.offset > eff_lim;
      end
      perm_bad = 1'b0;
      priv_bad = 1'b0;
      case (req.kind)
         sdc_pkg::SDC_RD: begin
            perm_bad = ~acc[sdc_pkg::SDC_A_S] |
                       (is_code & ~acc[sdc_pkg::SDC_A_WR]);
            priv_bad = ~(is_code & acc[sdc_pkg::SDC_A_EDC]) & lvl_low;
         end
         sdc_pkg::SDC_WR: begin
            perm_bad = ~is_data | ~acc[sdc_pkg::SDC_A_WR];
            priv_bad = lvl_low;
         end
         sdc_pkg::SDC_EX: begin
            perm_bad = ~is_code;
            priv_bad = acc[sdc_pkg::SDC_A_EDC] ?
               (req.current_privilege_level < segment_privilege_level) :
               (req.current_privilege_level != segment_privilege_level);
         end
         sdc_pkg::SDC_LOAD: begin
            perm_bad = ~is_data & ~(is_code & acc[sdc_pkg::SDC_A_WR]);
            priv_bad = ~(is_code & acc[sdc_pkg::SDC_A_EDC]) & lvl_low;
         end
         sdc_pkg::SDC_TEST: begin
            perm_bad = 1'b0;
         end
         default: begin
            perm_bad = acc[sdc_pkg::SDC_A_S] |
               ~(typ inside {sdc_pkg::SDC_T_TASKG, sdc_pkg::SDC_T_INTG,
                             sdc_pkg::SDC_T_TRAPG}) |
               ({5'h00, req.vector, 3'h7} > vlim);
         end
      endcase
      gp = is_vec ? perm_bad
         : (null_sel | perm_bad | priv_bad |
            (lim_bad & (req.kind inside {sdc_pkg::SDC_RD,
               sdc_pkg::SDC_WR, sdc_pkg::SDC_EX})));
   end

   // Response: the check and the answer are one registered stage
   always_comb begin
      next_rsp = '0;
      next_rsp.valid = req.valid;
      next_rsp.kind = req.kind;
      next_rsp.effective_privilege_level = effective_privilege_level;
      next_rsp.tbl = req.sel[2];
      next_rsp.index = req.sel[15:3];
      next_rsp.sys_known = ~acc[sdc_pkg::SDC_A_S] &
         (typ inside {sdc_pkg::SDC_T_LTAB, sdc_pkg::SDC_T_TASKG,
                      sdc_pkg::SDC_T_TSS, sdc_pkg::SDC_T_TSSB,
                      sdc_pkg::SDC_T_CALLG, sdc_pkg::SDC_T_INTG,
                      sdc_pkg::SDC_T_TRAPG});
      if (req.valid) begin
         if (gp) begin
            next_rsp.fault = 1'b1;
            next_rsp.fault_vec = sdc_pkg::SDC_VEC_GP;
         end else if (not_pres) begin
            next_rsp.fault = 1'b1;
            next_rsp.fault_vec = sdc_pkg::SDC_VEC_NP;
         end else begin
            next_rsp.ok = 1'b1;
         end
      end
      // A refused access never shows an address, so no memory cycle starts
      if (next_rsp.ok && !is_vec) begin
         next_rsp.phys = lin[sdc_pkg::SDC_PHYS_W-1:0];
      end
      next_rsp.acc_wr = next_rsp.ok &
         (req.kind inside {sdc_pkg::SDC_LOAD, sdc_pkg::SDC_TEST});
      next_rsp.acc_byte = acc | 8'h01;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   // Register file
   always_comb begin
      next_vlim = vlim;
      next_fcnt = fcnt;
      next_last_vec = last_vec;
      next_rdata = 32'h0000_0000;
      if (reg_wr && reg_addr == sdc_pkg::SDC_REG_VLIM) begin
         next_vlim = reg_wdata[15:0];
      end
      if (next_rsp.fault) begin
         next_fcnt = fcnt + 16'h0001;
         next_last_vec = next_rsp.fault_vec;
      end
      // Counter write wins only when no fault lands in that cycle
      if (reg_wr && reg_addr == sdc_pkg::SDC_REG_FCNT &&
          !next_rsp.fault) begin
         next_fcnt = reg_wdata[15:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            sdc_pkg::SDC_REG_VLIM: next_rdata = {16'h0000, vlim};
            sdc_pkg::SDC_REG_STAT: next_rdata = {24'h00_0000, last_vec};
            sdc_pkg::SDC_REG_FCNT: next_rdata = {16'h0000, fcnt};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vlim <= sdc_pkg::SDC_VLIM_RST;
         fcnt <= 16'h0000;
         last_vec <= 8'h00;
         reg_rdata <= 32'h0000_0000;
      end else begin
         vlim <= next_vlim;
         fcnt <= next_fcnt;
         last_vec <= next_last_vec;
         reg_rdata <= next_rdata;
      end
   end

   // Checks
   property p_np;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && not_pres && !gp |=>
         rsp.fault && rsp.fault_vec == 8'h0b && !rsp.ok;
   endproperty
   a_np: assert property (p_np) else $error("not present missed");

   property p_wr;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_WR && !acc[1] |=>
         rsp.fault && rsp.fault_vec == 8'h0d;
   endproperty
   a_wr: assert property (p_wr) else $error("write allowed");

   property p_rd;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_RD && acc[4] && acc[3]
         && !acc[1] |=> rsp.fault;
   endproperty
   a_rd: assert property (p_rd) else $error("code read allowed");

   property p_up;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_RD && acc[4] && !acc[3]
         && !acc[2] && req.offset > eff_lim |=> !rsp.ok;
   endproperty
   a_up: assert property (p_up) else $error("over limit");

   property p_dn;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_RD && acc[4] && !acc[3]
         && acc[2] && req.offset <= eff_lim |=> !rsp.ok;
   endproperty
   a_dn: assert property (p_dn) else $error("expand down");

   property p_conf;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_EX && acc[2]
         && req.current_privilege_level < acc[6:5] |=> rsp.fault;
   endproperty
   a_conf: assert property (p_conf) else $error("conforming");

   property p_null;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && !is_vec && req.sel[15:2] == 14'h0000 |=>
         rsp.fault && rsp.fault_vec == 8'h0d;
   endproperty
   a_null: assert property (p_null) else $error("null used");

   property p_phys;
      @(posedge mclk) disable iff (!rst_n)
      rsp.ok && !$past(is_vec) |->
         rsp.phys == $past(req.desc[39:16]) + $past(req.offset[23:0]);
   endproperty
   a_phys: assert property (p_phys) else $error("bad address");

   property p_abort;
      @(posedge mclk) disable iff (!rst_n)
      rsp.fault |-> rsp.phys == 24'h00_0000 && !rsp.acc_wr;
   endproperty
   a_abort: assert property (p_abort) else $error("not aborted");

   property p_acc;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && req.kind == sdc_pkg::SDC_TEST && !null_sel
         && !not_pres |=> rsp.acc_wr && rsp.acc_byte[0];
   endproperty
   a_acc: assert property (p_acc) else $error("accessed");

   property p_eff_lvl;
      @(posedge mclk) disable iff (!rst_n)
      req.valid |=> rsp.effective_privilege_level ==
         (($past(req.sel[1:0]) > $past(req.desc[46:45])) ?
          $past(req.sel[1:0]) : $past(req.desc[46:45]));
   endproperty
   a_eff_lvl: assert property (p_eff_lvl) else $error("bad level");

   property p_gate;
      @(posedge mclk) disable iff (!rst_n)
      req.valid && is_vec && (acc[4] || typ == 4'h9) |=>
         rsp.fault && rsp.fault_vec == 8'h0d;
   endproperty
   a_gate: assert property (p_gate) else $error("bad gate");
endmodule

// >>> sdc_pkg.sv
/*
 Constants and carrier types for the segment descriptor checker.
 Assumes one core clock; requests come from logic on that clock.
*/
package sdc_pkg;
   // Descriptor field positions
   localparam int SDC_LIML_LSB = 0;
   localparam int SDC_BASE_LSB = 16;
   localparam int SDC_ACC_LSB = 40;
   localparam int SDC_LIMH_LSB = 48;
   localparam int SDC_FREE_BIT = 52;
   localparam int SDC_G_BIT = 55;
   // Access byte bit positions
   localparam int SDC_A_P = 7;
   localparam int SDC_A_PRIV = 5;
   localparam int SDC_A_S = 4;
   localparam int SDC_A_E = 3;
   localparam int SDC_A_EDC = 2;
   localparam int SDC_A_WR = 1;
   localparam int SDC_A_ACC = 0;
   // Geometry
   localparam int SDC_PHYS_W = 24;
   localparam int SDC_VEC_CNT = 256;
   localparam logic [11:0] SDC_GRAN_FILL = 12'hfff;
   // Fault vectors
   localparam logic [7:0] SDC_VEC_NP = 8'h0b;
   localparam logic [7:0] SDC_VEC_GP = 8'h0d;
   // System type codes
   localparam logic [3:0] SDC_T_LTAB = 4'h2;
   localparam logic [3:0] SDC_T_TASKG = 4'h5;
   localparam logic [3:0] SDC_T_TSS = 4'h9;
   localparam logic [3:0] SDC_T_TSSB = 4'hb;
   localparam logic [3:0] SDC_T_CALLG = 4'hc;
   localparam logic [3:0] SDC_T_INTG = 4'he;
   localparam logic [3:0] SDC_T_TRAPG = 4'hf;
   // Register port
   localparam logic [3:0] SDC_REG_VLIM = 4'h0;
   localparam logic [3:0] SDC_REG_STAT = 4'h4;
   localparam logic [3:0] SDC_REG_FCNT = 4'h8;
   localparam logic [15:0] SDC_VLIM_RST = 16'h07ff;

   typedef enum logic [2:0] {
      SDC_RD = 3'h0, SDC_WR = 3'h1, SDC_EX = 3'h2, SDC_LOAD = 3'h3,
      SDC_TEST = 3'h4, SDC_VSW = 3'h5, SDC_VEXT = 3'h6, SDC_VEXC = 3'h7
   } sdc_kind_t;

   typedef struct packed {
      logic valid;
      sdc_kind_t kind;
      logic [1:0] current_privilege_level;
      logic [15:0] sel;
      logic [63:0] desc;
      logic [31:0] offset;
      logic [7:0] vector;
   } sdc_req_t;

   typedef struct packed {
      logic valid;
      logic ok;
      logic fault;
      logic [7:0] fault_vec;
      sdc_kind_t kind;
      logic [23:0] phys;
      logic [1:0] effective_privilege_level;
      logic tbl;
      logic [12:0] index;
      logic sys_known;
      logic acc_wr;
      logic [7:0] acc_byte;
   } sdc_rsp_t;
endpackage

// >>> sdc_tbl_model.sv
/*
 Descriptor table model: global, per-task and vector tables.
 Assumes the bench loads entries by put tasks just after a clock edge.
*/
`timescale 1ns/1ps
module sdc_tbl_model (
   // Lookup
   input wire logic [15:0] sel,
   input wire logic [7:0] vector,
   // Entries
   output logic [63:0] desc,
   output logic [63:0] gate
);
   logic [63:0] gtab [0:15];
   logic [63:0] ltab [0:15];
   logic [63:0] vtab [0:255];
   initial begin
      for (int i = 0; i < 256; i++) begin
         vtab[i] = '0;
         if (i < 16) begin
            gtab[i] = '0;
            ltab[i] = '0;
         end
      end
   end
   // Sixteen slots in the global and per-task tables keep the model small
   assign desc = sel[2] ? ltab[sel[6:3]] : gtab[sel[6:3]];
   assign gate = vtab[vector];
   task put(input logic t, input logic [3:0] i, input logic [63:0] d);
      if (t) ltab[i] <= d;
      else if (i != 4'h0) gtab[i] <= d;
   endtask
   task put_vec(input logic [7:0] v, input logic [63:0] d);
      vtab[v] <= d;
   endtask
endmodule

// >>> tb.sv
/*
 Self-checking bench: random checks against a reference, register port.
 Assumes the table model feeds descriptors in the request cycle.
*/
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   sdc_pkg::sdc_req_t rq = '0;
   sdc_pkg::sdc_req_t req;
   sdc_pkg::sdc_rsp_t rsp;
   sdc_pkg::sdc_rsp_t expv = '0;
   logic pend = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [63:0] tdesc;
   logic [63:0] tgate;
   logic [15:0] vlim = 16'h07ff;
   logic [31:0] lf = 32'h6a02_233b;
   logic [7:0] lastf = 8'h00;
   int n_errors = 0;
   int comparisons = 0;
   int nfault = 0;

   always #5 mclk = ~mclk;
   sdc_tbl_model tbl (.sel(rq.sel), .vector(rq.vector), .desc(tdesc),
      .gate(tgate));
   always_comb begin
      req = rq;
      req.desc = (rq.kind >= sdc_pkg::SDC_VSW) ? tgate : tdesc;
   end
   sdc_check uut (.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
   endfunction

   function automatic sdc_pkg::sdc_rsp_t model(sdc_pkg::sdc_req_t r,
      logic [15:0] vl);
      sdc_pkg::sdc_rsp_t e;
      logic [7:0] ab;
      logic [31:0] lim;
      logic code, data, inl, gp;
      logic [1:0] cur, eff;
      ab = r.desc[47:40];
      code = ab[4] & ab[3];
      data = ab[4] & ~ab[3];
      lim = {12'h000, r.desc[51:48], r.desc[15:0]};
      if (r.desc[55]) lim = {lim[19:0], 12'hfff};
      inl = (data & ab[2]) ? (r.offset > lim) : (r.offset <= lim);
      e = '0;
      e.valid = r.valid;
      e.kind = r.kind;
      cur = r.current_privilege_level;
      eff = (r.sel[1:0] > ab[6:5]) ? r.sel[1:0] : ab[6:5];
      e.effective_privilege_level = eff;
      e.tbl = r.sel[2];
      e.index = r.sel[15:3];
      e.sys_known = ~ab[4] &
         (ab[3:0] inside {4'h2, 4'h5, 4'h9, 4'hb, 4'hc, 4'he, 4'hf});
      e.acc_byte = ab | 8'h01;
      gp = 1'b0;
      if (r.kind >= sdc_pkg::SDC_VSW)
         gp = ab[4] | !(ab[3:0] inside {4'h5, 4'he, 4'hf}) |
            ({r.vector, 3'h7} > vl);
      else if (r.sel[15:2] == 14'h0000) gp = 1'b1;
      else begin
         case (r.kind)
            sdc_pkg::SDC_RD, sdc_pkg::SDC_LOAD: gp = ~ab[4] |
               (code & ~ab[1]) | ((data | ~ab[2]) & (eff < cur));
            sdc_pkg::SDC_WR: gp = ~data | ~ab[1] | (eff < cur);
            sdc_pkg::SDC_EX: gp = ~code |
               (ab[2] ? (cur < ab[6:5]) : (cur != ab[6:5]));
            default: gp = 1'b0;
         endcase
         if (r.kind <= sdc_pkg::SDC_EX) gp = gp | ~inl;
      end
      e.fault = gp | ~ab[7];
      e.fault_vec = gp ? sdc_pkg::SDC_VEC_GP : sdc_pkg::SDC_VEC_NP;
      e.ok = ~e.fault;
      if (e.ok && r.kind < sdc_pkg::SDC_VSW)
         e.phys = r.desc[39:16] + r.offset[23:0];
      e.acc_wr = e.ok & (r.kind inside {sdc_pkg::SDC_LOAD, sdc_pkg::SDC_TEST});
      return e;
   endfunction

   task chk(input logic good, input string what);
      comparisons++;
      if (!good) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask

   task final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge mclk) begin
      pend <= req.valid;
      expv <= model(req, vlim);
   end

   // Sampled mid-cycle so the answer edge has settled
   always @(negedge mclk) begin
      if (rst_n) begin
         chk(rsp.valid === pend, "answer timing");
         if (pend) begin
            chk({rsp.ok, rsp.fault} === {expv.ok, expv.fault},
               "verdict");
            if (expv.fault)
               chk(rsp.fault_vec === expv.fault_vec, "fault");
            chk(rsp.phys === expv.phys, "address");
            chk({rsp.effective_privilege_level, rsp.tbl, rsp.index} ===
               {expv.effective_privilege_level, expv.tbl, expv.index},
               "selector");
            chk({rsp.sys_known, rsp.kind} === {expv.sys_known, expv.kind},
               "class");
            chk(rsp.acc_byte === expv.acc_byte, "accessed");
            chk(rsp.acc_wr === expv.acc_wr, "write back");
            if (expv.fault) begin
               nfault++;
               lastf = expv.fault_vec;
            end
         end
      end
   end

   task reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task reg_read(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(reg_rdata === e, "register");
   endtask

   // Offsets land on the limit and its neighbours to hit both boundaries
   task traffic(input int n);
      logic [63:0] d;
      logic [31:0] lim;
      logic [7:0] v;
      repeat (n) begin
         @(posedge mclk);
         lf = lfsr(lf);
         d[31:0] = lf;
         lf = lfsr(lf);
         d[63:32] = lf;
         lf = lfsr(lf);
         lim = d[55] ? {d[51:48], d[15:0], 12'hfff} :
            {12'h000, d[51:48], d[15:0]};
         v = {2'b00, lf[19:14]};
         rq.valid <= lf[8] | lf[9];
         rq.kind <= sdc_pkg::sdc_kind_t'(lf[2:0]);
         rq.current_privilege_level <= lf[11:10];
         rq.sel <= {9'h000, lf[6:3], lf[7], lf[13:12]};
         rq.vector <= v;
         rq.offset <= (lf[23:22] == 2'h3) ? lf :
            lim + 32'(lf[23:22]) - 32'h0000_0001;
         d[47] = d[47] | lf[28];
         tbl.put(lf[7], lf[6:3], d);
         d[44] = lf[24] & lf[25];
         if (lf[26]) d[43:40] = {3'b111, lf[27]};
         tbl.put_vec(v, d);
      end
      @(posedge mclk);
      rq.valid <= 1'b0;
      @(posedge mclk);
   endtask

   initial begin
      #200000;
      n_errors++;
      $display("[FAIL] %0t run limit reached", $time);
      final_report();
   end

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      reg_read(sdc_pkg::SDC_REG_VLIM, 32'h0000_07ff);
      reg_read(4'hc, 32'h0000_0000);
      reg_write(sdc_pkg::SDC_REG_FCNT, 32'h0000_0000);
      traffic(300);
      reg_read(sdc_pkg::SDC_REG_STAT, {24'h00_0000, lastf});
      reg_read(sdc_pkg::SDC_REG_FCNT, {16'h0000, nfault[15:0]});
      $display("test full vector table done");
      reg_write(sdc_pkg::SDC_REG_VLIM, 32'h0000_00ff);
      vlim <= 16'h00ff;
      traffic(300);
      reg_read(sdc_pkg::SDC_REG_FCNT, {16'h0000, nfault[15:0]});
      $display("test short vector table done");
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      vlim <= 16'h07ff;
      reg_read(sdc_pkg::SDC_REG_VLIM, 32'h0000_07ff);
      reg_read(sdc_pkg::SDC_REG_FCNT, 32'h0000_0000);
      $display("test second reset done");
      final_report();
   end
endmodule
